/* File: slt_pkg.sv */
package slt_pkg;

    // ----------------------------------------
    // Register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [9:0] IDX_BUF_EMPTY = 10'h30d;
    localparam logic [9:0] IDX_SYNC_GEN = 10'h312;
    localparam logic [9:0] IDX_PORT_CLK = 10'h314;
    localparam logic [9:0] IDX_BERT_EN = 10'h315;
    localparam logic [9:0] IDX_BERT_CTRL = 10'h316;
    localparam logic [9:0] IDX_THR_LO = 10'h317;
    localparam logic [9:0] IDX_THR_MID = 10'h318;
    localparam logic [9:0] IDX_THR_HI = 10'h319;
    localparam logic [9:0] IDX_CNT_LO = 10'h31a;
    localparam logic [9:0] IDX_CNT_MID = 10'h31b;
    localparam logic [9:0] IDX_CNT_HI = 10'h31c;
    localparam logic [9:0] IDX_BERT_PASS = 10'h31d;
    localparam logic [9:0] IDX_CHK_CTRL = 10'h32c;
    localparam logic [9:0] IDX_REF_LO = 10'h32d;
    localparam logic [9:0] IDX_REF_HI = 10'h32e;
    localparam logic [9:0] IDX_CHK_STAT = 10'h32f;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h340;
    localparam logic [9:0] IDX_IRQ_EN = 10'h341;
    localparam logic [9:0] IDX_IRQ_CLR = 10'h342;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int SYNC_DUR_LSB = 4;
    localparam int BERT_LANE_LSB = 4;
    localparam int BERT_PAT_LSB = 2;
    localparam int BERT_RUN_BIT = 1;
    localparam int BERT_CLR_BIT = 0;
    localparam int CHK_SP_LSB = 4;
    localparam int CHK_M_LSB = 2;
    localparam int CHK_CLR_BIT = 1;
    localparam int CHK_EN_BIT = 0;
    localparam logic [7:0] PASS_RESET = 8'hff;
    localparam logic [23:0] COUNT_MAX = 24'hffffff;
    localparam logic [4:0] PRBS_FILL = 5'h1f;
    localparam int IRQ_SYNC = 0;
    localparam int IRQ_BERT = 1;
    localparam int IRQ_CHK = 2;
    localparam int IRQ_W = 3;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned MCLK_PERIOD_PS = 4000;
    localparam int unsigned PCLK_PERIOD_PS = 16000;
    // Half a link clock, rounded up, never below one cycle
    localparam int unsigned SYNC_HALF_RAW = (PCLK_PERIOD_PS / 2 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
    localparam logic [4:0] SYNC_HALF_CYC = 5'((SYNC_HALF_RAW < 1) ? 1 : SYNC_HALF_RAW);

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        PAT_PRBS7 = 2'h0,
        PAT_PRBS15 = 2'h1,
        PAT_PRBS31 = 2'h2,
        PAT_NONE = 2'h3
    } slt_pattern_t;

    typedef enum logic {
        SYNC_IDLE = 1'b0,
        SYNC_LOW = 1'b1
    } slt_sync_state_t;

    // Settings shared by all lane checkers
    typedef struct packed {
        logic run;
        logic clear;
        slt_pattern_t pattern;
        logic [23:0] threshold;
    } slt_bert_cfg_t;

    // Converter-by-position received samples
    typedef logic [3:0][3:0][15:0] slt_samples_t;

endpackage : slt_pkg

/* File: slt_sync_pulse.sv */
module slt_sync_pulse
    import slt_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Link error inputs
    input wire logic [7:0] char_error,
    input wire logic multiframe_end,
    input wire logic [1:0] dur_sel,
    // Outputs
    output logic [1:0] sync_request_output_n,
    output logic sync_error
);

    typedef struct packed {
        logic seen_err;
        slt_sync_state_t state;
        logic [4:0] cnt;
        logic err_pulse;
    } slt_sync_st_t;

    slt_sync_st_t s; // Registered state
    slt_sync_st_t next_s; // Next state
    logic [4:0] len; // Low time in mclk cycles
    logic start; // Sync error at multiframe close

    // ----------------------------------------
    // Low time and next state
    // ----------------------------------------
    always_comb begin
        case (dur_sel)
            2'h0: len = SYNC_HALF_CYC;
            2'h1: len = 5'(SYNC_HALF_CYC << 1);
            default: len = 5'(SYNC_HALF_CYC << 2);
        endcase
        start = multiframe_end && (s.seen_err || (|char_error));
        next_s = s;
        next_s.err_pulse = 1'b0;
        if (|char_error) begin
            next_s.seen_err = 1'b1;
        end
        // New multiframe starts clean
        if (multiframe_end) begin
            next_s.seen_err = 1'b0;
        end
        case (s.state)
            SYNC_LOW: begin
                if (s.cnt == 5'h0) begin
                    next_s.state = SYNC_IDLE;
                end else begin
                    next_s.cnt = s.cnt - 5'h1;
                end
            end
            default: begin
            end
        endcase
        // a new error restarts the low time
        if (start) begin
            next_s.state = SYNC_LOW;
            next_s.cnt = len - 5'h1;
            next_s.err_pulse = 1'b1;
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Both outputs low together
    assign sync_request_output_n = {2{s.state != SYNC_LOW}};
    assign sync_error = s.err_pulse;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_sync_load: assert property (@(posedge mclk) disable iff (!rst_n)
        s.err_pulse |-> (s.state == SYNC_LOW && s.cnt == $past(len) - 5'h1))
        else $error("sync low time loaded wrong");
    a_sync_release: assert property (@(posedge mclk) disable iff (!rst_n)
        (s.state == SYNC_LOW && s.cnt == 5'h0 && !start) |=> sync_request_output_n == 2'h3)
        else $error("sync output held too long");

endmodule : slt_sync_pulse

/* File: slt_bert_lane.sv */
module slt_bert_lane
    import slt_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Settings
    input wire logic lane_enable,
    input wire slt_bert_cfg_t cfg,
    // Received serial bits
    input wire logic rx_bit,
    input wire logic rx_valid,
    // Results
    output logic [23:0] err_count,
    output logic pass,
    output logic fail_event
);

    typedef struct packed {
        logic [30:0] hist;
        logic [4:0] fill;
        logic [23:0] count;
        logic pass;
    } slt_lane_st_t;

    slt_lane_st_t s; // Registered state
    slt_lane_st_t next_s; // Next state

    // Self-synchronising predictor from past received bits
    function automatic logic prbs_predict(input slt_pattern_t p, input logic [30:0] h);
        case (p)
            PAT_PRBS7: prbs_predict = h[6] ^ h[5];
            PAT_PRBS15: prbs_predict = h[14] ^ h[13];
            default: prbs_predict = h[30] ^ h[27];
        endcase
    endfunction : prbs_predict

    // ----------------------------------------
    // Checker next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        if (cfg.clear) begin
            next_s = '0;
            next_s.pass = 1'b1;
        end else if (lane_enable && cfg.run && rx_valid) begin
            next_s.hist = {s.hist[29:0], rx_bit};
            if (s.fill != PRBS_FILL) begin
                next_s.fill = s.fill + 5'h1;
            end
            // pattern 3 counts nothing; count mismatches
            if (s.fill == PRBS_FILL && cfg.pattern != PAT_NONE
                    && rx_bit != prbs_predict(cfg.pattern, s.hist) && s.count != COUNT_MAX) begin
                next_s.count = s.count + 24'h1;
            end
        end
        if (!cfg.clear && next_s.count > cfg.threshold) begin
            next_s.pass = 1'b0;
        end
    end

    // State register, pass starts high
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= '{hist: '0, fill: '0, count: '0, pass: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    assign err_count = s.count;
    assign pass = s.pass;
    assign fail_event = s.pass && !next_s.pass;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_bert_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg.clear |=> (s.count == 24'h0 && s.pass))
        else $error("clear did not reset lane");
    a_bert_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        (!cfg.run && !cfg.clear) |=> s.count == $past(s.count))
        else $error("count moved while stopped");
    a_bert_unused: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfg.pattern == PAT_NONE && !cfg.clear) |=> s.count == $past(s.count))
        else $error("count moved on unused pattern");
    a_bert_fail: assert property (@(posedge mclk) disable iff (!rst_n)
        (!cfg.clear && next_s.count > cfg.threshold) |=> !s.pass)
        else $error("pass kept above threshold");

endmodule : slt_bert_lane

/* File: slt_top.sv */
// Added by the designer: register access over Wishbone.
module slt_top
    import slt_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Link layer status
    input wire logic [7:0] lane_buffer_empty,
    input wire logic [7:0] lane_char_error,
    input wire logic multiframe_end,
    // Lane bit streams
    input wire logic [7:0] lane_rx_bit,
    input wire logic [7:0] lane_rx_valid,
    // Transport samples
    input wire slt_samples_t samples,
    input wire logic sample_valid,
    // Outputs
    output logic [1:0] sync_request_output_n,
    output logic irq
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] sync_gen;
        logic port_clk_sel;
        logic [7:0] lane_en;
        logic [6:0] bert_ctrl;
        logic [23:0] thr;
        logic [5:0] chk_ctrl;
        logic [15:0] ref_sample;
        logic chk_fail;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic ack;
        logic [31:0] rdata;
    } slt_regs_t;

    slt_regs_t s; // Registered state
    slt_regs_t next_s; // Next state
    slt_bert_cfg_t bert_cfg; // Shared lane settings
    logic [7:0][23:0] lane_count; // Per-lane counts
    logic [7:0] bert_pass; // Per-lane pass flags
    logic [7:0] lane_fail; // Pass flag falling
    logic sync_error; // Sync error pulse
    logic [9:0] idx; // Register index
    logic take; // Request taken this edge
    logic wr; // Write with low lane enabled
    logic [7:0] wbyte; // Written byte
    logic [2:0] lane_sel; // Reported lane
    logic [15:0] chk_sample; // Sample under check
    logic chk_miss; // Compare failed this cycle
    logic chk_clr; // Result clear strobe
    logic [IRQ_W-1:0] irq_set; // Event strobes

    // ----------------------------------------
    // Sync request generator
    // ----------------------------------------
    slt_sync_pulse u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .char_error(lane_char_error),
        .multiframe_end(multiframe_end),
        .dur_sel(s.sync_gen[SYNC_DUR_LSB +: 2]),
        .sync_request_output_n(sync_request_output_n),
        .sync_error(sync_error)
    );

    // ----------------------------------------
    // Lane bit-error checkers
    // ----------------------------------------
    assign bert_cfg.run = s.bert_ctrl[BERT_RUN_BIT];
    assign bert_cfg.clear = s.bert_ctrl[BERT_CLR_BIT];
    assign bert_cfg.pattern = slt_pattern_t'(s.bert_ctrl[BERT_PAT_LSB +: 2]);
    assign bert_cfg.threshold = s.thr;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_lane
            slt_bert_lane u_lane (
                .mclk(mclk),
                .rst_n(rst_n),
                .lane_enable(s.lane_en[g]),
                .cfg(bert_cfg),
                .rx_bit(lane_rx_bit[g]),
                .rx_valid(lane_rx_valid[g]),
                .err_count(lane_count[g]),
                .pass(bert_pass[g]),
                .fail_event(lane_fail[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Bus decode helpers
    // ----------------------------------------
    assign idx = wb_adr_i[11:2];
    // One answer per request; the cycle with ack high is never taken
    assign take = wb_cyc_i && wb_stb_i && !s.ack;
    // Data sits in the low byte, so only its lane enable matters
    assign wr = take && wb_we_i && wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign lane_sel = s.bert_ctrl[BERT_LANE_LSB +: 3];

    // ----------------------------------------
    // Sample check compare
    // ----------------------------------------
    always_comb begin
        chk_sample = samples[s.chk_ctrl[CHK_M_LSB +: 2]][s.chk_ctrl[CHK_SP_LSB +: 2]];
        chk_miss = s.chk_ctrl[CHK_EN_BIT] && sample_valid && (chk_sample != s.ref_sample);
        chk_clr = wr && idx == IDX_CHK_CTRL && wbyte[CHK_CLR_BIT];
    end

    // Events feeding the sticky status
    assign irq_set = {chk_miss, |lane_fail, sync_error};

    // ----------------------------------------
    // Register file next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.ack = take;
        // Sample check result, mismatch beats a clear in the same cycle
        if (s.chk_ctrl[CHK_EN_BIT] && sample_valid) begin
            // 0 on match, 1 on mismatch
            next_s.chk_fail = chk_miss;
        end else if (chk_clr) begin
            next_s.chk_fail = 1'b0;
        end
        if (chk_clr && chk_miss) begin
            next_s.chk_fail = 1'b1;
        end
        // Register writes
        if (wr) begin
            if (idx == IDX_SYNC_GEN) begin
                next_s.sync_gen = wbyte;
            end else if (idx == IDX_PORT_CLK) begin
                next_s.port_clk_sel = wbyte[0];
            end else if (idx == IDX_BERT_EN) begin
                next_s.lane_en = wbyte;
            end else if (idx == IDX_BERT_CTRL) begin
                next_s.bert_ctrl = wbyte[6:0];
            end else if (idx == IDX_THR_LO) begin
                next_s.thr[7:0] = wbyte;
            end else if (idx == IDX_THR_MID) begin
                next_s.thr[15:8] = wbyte;
            end else if (idx == IDX_THR_HI) begin
                next_s.thr[23:16] = wbyte;
            end else if (idx == IDX_CHK_CTRL) begin
                // Clear bit acts once and reads back as zero
                next_s.chk_ctrl = {wbyte[5:2], 1'b0, wbyte[0]};
            end else if (idx == IDX_REF_LO) begin
                next_s.ref_sample[7:0] = wbyte;
            end else if (idx == IDX_REF_HI) begin
                next_s.ref_sample[15:8] = wbyte;
            end else if (idx == IDX_IRQ_EN) begin
                next_s.irq_en = wbyte[IRQ_W-1:0];
            end else if (idx == IDX_IRQ_CLR) begin
                next_s.irq_stat = s.irq_stat & ~wbyte[IRQ_W-1:0];
            end else begin
                // Read-only or unmapped: write ignored
            end
        end
        // Set wins over a clear in the same cycle
        next_s.irq_stat = next_s.irq_stat | irq_set;
        // Read data, captured as ack rises
        next_s.rdata = 32'h0;
        if (take && !wb_we_i) begin
            if (idx == IDX_BUF_EMPTY) begin
                next_s.rdata[7:0] = lane_buffer_empty;
            end else if (idx == IDX_SYNC_GEN) begin
                next_s.rdata[7:0] = s.sync_gen;
            end else if (idx == IDX_PORT_CLK) begin
                next_s.rdata[7:0] = {7'h0, s.port_clk_sel};
            end else if (idx == IDX_BERT_EN) begin
                next_s.rdata[7:0] = s.lane_en;
            end else if (idx == IDX_BERT_CTRL) begin
                next_s.rdata[7:0] = {1'b0, s.bert_ctrl};
            end else if (idx == IDX_THR_LO) begin
                next_s.rdata[7:0] = s.thr[7:0];
            end else if (idx == IDX_THR_MID) begin
                next_s.rdata[7:0] = s.thr[15:8];
            end else if (idx == IDX_THR_HI) begin
                next_s.rdata[7:0] = s.thr[23:16];
            end else if (idx == IDX_CNT_LO) begin
                next_s.rdata[7:0] = lane_count[lane_sel][7:0];
            end else if (idx == IDX_CNT_MID) begin
                next_s.rdata[7:0] = lane_count[lane_sel][15:8];
            end else if (idx == IDX_CNT_HI) begin
                next_s.rdata[7:0] = lane_count[lane_sel][23:16];
            end else if (idx == IDX_BERT_PASS) begin
                next_s.rdata[7:0] = bert_pass;
            end else if (idx == IDX_CHK_CTRL) begin
                next_s.rdata[7:0] = {2'h0, s.chk_ctrl};
            end else if (idx == IDX_REF_LO) begin
                next_s.rdata[7:0] = s.ref_sample[7:0];
            end else if (idx == IDX_REF_HI) begin
                next_s.rdata[7:0] = s.ref_sample[15:8];
            end else if (idx == IDX_CHK_STAT) begin
                next_s.rdata[7:0] = {7'h0, s.chk_fail};
            end else if (idx == IDX_IRQ_STAT) begin
                next_s.rdata[IRQ_W-1:0] = s.irq_stat;
            end else if (idx == IDX_IRQ_EN) begin
                next_s.rdata[IRQ_W-1:0] = s.irq_en;
            end else begin
                // Unmapped and write-only read as zero
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdata;
    assign irq = |(s.irq_stat & s.irq_en);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking

    // Read request of one register
    sequence s_rd_take(logic [9:0] r);
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && idx == r;
    endsequence

    // Error seen and multiframe closes
    sequence s_mf_err;
        (|lane_char_error) ##1 (multiframe_end && !(|lane_char_error))[*1];
    endsequence

    a_sync_err_low: assert property (disable iff (!rst_n)
        s_mf_err |=> ##1 sync_request_output_n == 2'h0)
        else $error("sync outputs not low after error");
    a_empty_read: assert property (disable iff (!rst_n)
        s_rd_take(IDX_BUF_EMPTY) |=> (wb_ack_o && wb_dat_o[7:0] == $past(lane_buffer_empty)))
        else $error("empty flags read wrong");
    a_count_select: assert property (disable iff (!rst_n)
        s_rd_take(IDX_CNT_HI) |=> wb_dat_o[7:0] == $past(lane_count[lane_sel][23:16]))
        else $error("selected count read wrong");
    a_pass_reset: assert property (!rst_n |=> bert_pass == PASS_RESET)
        else $error("pass flags not set after reset");
    a_chk_fail: assert property (disable iff (!rst_n)
        chk_miss |=> (s.chk_fail && s.irq_stat[IRQ_CHK]))
        else $error("mismatch not flagged");
    a_chk_clear: assert property (disable iff (!rst_n)
        (chk_clr && !(s.chk_ctrl[CHK_EN_BIT] && sample_valid)) |=> !s.chk_fail)
        else $error("check clear ignored");
    a_ack_single: assert property (disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held over two cycles");

endmodule : slt_top

/* File: slt_prbs_tx.sv */
module slt_prbs_tx
    import slt_pkg::*;
(
    // Clock and control
    input wire logic mclk,
    input wire logic go,
    input wire logic flip,
    input wire logic [1:0] pat,
    // Lane streams
    output logic [7:0] rx_bit,
    output logic [7:0] rx_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sender history, any nonzero seed, reloaded while idle so every run starts alive
    logic [30:0] s = 31'h5a5a5a5a;
    logic nb;
    assign nb = (pat == 2'h0) ? s[6] ^ s[5] : (pat == 2'h1) ? s[14] ^ s[13] : s[30] ^ s[27];
    initial rx_bit = 8'h00;
    initial rx_valid = 8'h00;
    always @(posedge mclk) begin
        if (go) begin
            s <= {s[29:0], nb};
            // Lanes 0 and 2 take the injected errors
            rx_bit <= {{5{nb}}, nb ^ flip, nb, nb ^ flip};
            rx_valid <= 8'hff;
        end else begin
            s <= 31'h5a5a5a5a;
            // Idle lines toggle so stale bits never look valid
            rx_bit <= ~rx_bit;
            rx_valid <= 8'h00;
        end
    end
endmodule : slt_prbs_tx

/* File: serial_lane_test_and_status_tb.sv */
module serial_lane_test_and_status_tb
    import slt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n, cyc, stb, we, mfe, sv, go, flip, ack, irq;
    logic [11:0] adr;
    logic [31:0] dat, rdo, rdat;
    logic [7:0] be, ce, rb, rv;
    logic [1:0] syn_n;
    logic [1:0] pat;
    logic anyf;
    logic [15:0] r = 16'hefe3;
    logic [15:0] rf;
    slt_samples_t smp, t;
    int err_count, checks_done, tmo, ecnt, c;
    // Model history of lane 0, newest last
    logic h[$];
    slt_top i_slt_top (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
        .lane_buffer_empty(be), .lane_char_error(ce), .multiframe_end(mfe), .lane_rx_bit(rb),
        .lane_rx_valid(rv), .samples(smp), .sample_valid(sv), .sync_request_output_n(syn_n), .irq(irq));
    slt_prbs_tx i_slt_prbs_tx (.mclk(mclk), .go(go), .flip(flip), .pat(pat), .rx_bit(rb), .rx_valid(rv));
    initial begin
        mclk = 0;
        forever #2 mclk = ~mclk;
    end
    // Random source for stimulus
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nx
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("FAIL t=%0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    // Classic single cycle, held until ack seen at an edge
    task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {i, 2'b00};
        dat <= {24'h0, d};
        do @(posedge mclk); while (ack !== 1'b1);
        rdat = rdo;
        cyc <= 0;
        stb <= 0;
        @(posedge mclk);
    endtask : wb
    task automatic rd(input logic [9:0] i, input logic [7:0] e);
        wb(0, i, 8'h00);
        chk(rdat, {24'h0, e});
    endtask : rd
    // Hang guard, well above the run length
    always @(posedge mclk) begin
        if (++tmo == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    // Error count model: predictor of the chosen polynomial after 31 fill bits, none for pattern 3
    always @(posedge mclk) begin
        if (rv[0] === 1'b1) begin
            if (h.size() >= 31 && pat != 2'h3 && rb[0] != (pat == 2'h0 ? h[h.size()-7] ^ h[h.size()-6] :
                    pat == 2'h1 ? h[h.size()-15] ^ h[h.size()-14] : h[h.size()-31] ^ h[h.size()-28])) ecnt++;
            h.push_back(rb[0]);
        end
    end
    initial begin
        {rst_n, cyc, stb, we, mfe, sv, go, flip, anyf, pat} = '0;
        adr = 0;
        dat = 0;
        be = 0;
        ce = 0;
        smp = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        rd(IDX_BERT_PASS, 8'hff);
        wb(1, IDX_BERT_PASS, 8'h00);
        rd(IDX_BERT_PASS, 8'hff);
        rd(10'h3ff, 8'h00);
        r = nx(r);
        be <= r[7:0];
        rd(IDX_BUF_EMPTY, r[7:0]);
        wb(1, IDX_IRQ_EN, 8'h07);
        // Last pass has no link error, so no pulse
        for (int f = 0; f < 5; f++) begin
            wb(1, IDX_SYNC_GEN, 8'((f & 3) << 4));
            ce <= (f < 4) ? 8'h01 << f : 8'h00;
            @(posedge mclk);
            ce <= 0;
            mfe <= 1;
            @(posedge mclk);
            mfe <= 0;
            c = 0;
            repeat (12) begin
                @(posedge mclk);
                c += (syn_n === 2'b00);
            end
            chk(c, f == 4 ? 0 : f == 3 ? 8 : 2 << f);
        end
        // Odd passes spoil one reference byte
        for (int i = 0; i < 8; i++) begin
            for (int k = 0; k < 16; k++) begin
                r = nx(r);
                t[k/4][k%4] = r;
            end
            rf = t[i%4][i/2] ^ {i[1] & i[0], 14'h0, ~i[1] & i[0]};
            wb(1, IDX_REF_LO, rf[7:0]);
            wb(1, IDX_REF_HI, rf[15:8]);
            wb(1, IDX_CHK_CTRL, {2'b0, 2'(i / 2), 2'(i % 4), 2'b01});
            smp <= t;
            sv <= 1;
            @(posedge mclk);
            sv <= 0;
            @(posedge mclk);
            rd(IDX_CHK_STAT, {7'h0, i[0]});
        end
        wb(1, IDX_CHK_CTRL, 8'h02);
        rd(IDX_CHK_STAT, 8'h00);
        sv <= 1;
        @(posedge mclk);
        sv <= 0;
        @(posedge mclk);
        rd(IDX_CHK_STAT, 8'h00);
        wb(1, IDX_THR_LO, 8'h05);
        wb(1, IDX_BERT_EN, 8'h03);
        // One cleared run per pattern, PRBS7 last so its count stays for the lane select check
        for (int p = 3; p >= 0; p--) begin
            wb(1, IDX_BERT_CTRL, 8'h01);
            h.delete();
            ecnt = 0;
            pat <= 2'(p);
            wb(1, IDX_BERT_CTRL, 8'(p << 2) | 8'h02);
            for (int i = 0; i < 120; i++) begin
                r = nx(r);
                go <= 1;
                flip <= i > 40 && r[2:0] == 3'h0;
                @(posedge mclk);
            end
            go <= 0;
            flip <= 0;
            repeat (3) @(posedge mclk);
            wb(1, IDX_BERT_CTRL, 8'(p << 2));
            rd(IDX_CNT_LO, ecnt[7:0]);
            rd(IDX_CNT_MID, ecnt[15:8]);
            rd(IDX_CNT_HI, ecnt[23:16]);
            // Lane 2 sees errors too but is not enabled
            rd(IDX_BERT_PASS, {7'h7f, ecnt <= 5});
            anyf |= ecnt > 5;
        end
        wb(1, IDX_BERT_CTRL, 8'h10);
        rd(IDX_CNT_LO, 8'h00);
        wb(1, IDX_BERT_CTRL, 8'h01);
        rd(IDX_BERT_PASS, 8'hff);
        rd(IDX_CNT_LO, 8'h00);
        rd(IDX_IRQ_STAT, {5'h0, 1'b1, anyf, 1'b1});
        chk(irq, 1);
        wb(1, IDX_IRQ_EN, 8'h00);
        chk(irq, 0);
        wb(1, IDX_IRQ_CLR, 8'h07);
        rd(IDX_IRQ_STAT, 8'h00);
        wrap_up();
    end
endmodule : serial_lane_test_and_status_tb
